//--- core/bk3_pkg.sv
/*
  Shared constants and types for the third buck converter's mode and set-point control.
  Assumes a single 100 MHz clock domain and a synchronous active-high reset.
*/
package bk3_pkg;

  // ----------------------------------------------------------------
  // Clock and debounce timing
  // ----------------------------------------------------------------
  localparam int BK3_CLK_MHZ = 100;            // Control clock rate in MHz
  localparam int BK3_DEBOUNCE_US = 8000;       // Fault debounce, 8.0 ms in microseconds
  localparam int BK3_DEBOUNCE_CYC_INT = BK3_DEBOUNCE_US * BK3_CLK_MHZ;
  localparam int BK3_DB_W = 20;                // Debounce length width; the debounce counter is one bit wider
  localparam logic [BK3_DB_W-1:0] BK3_DEBOUNCE_CYCLES = BK3_DB_W'(BK3_DEBOUNCE_CYC_INT);

  // ----------------------------------------------------------------
  // Set-point fields and voltage decode
  // ----------------------------------------------------------------
  localparam int BK3_SP_W = 6;                 // Set-point field width
  localparam int BK3_CODE_W = 4;               // Used low bits of a set-point field
  localparam int BK3_MV_W = 12;                // Millivolt result width
  localparam logic [BK3_SP_W-1:0] BK3_SP_RESET = 6'h00;
  localparam logic [BK3_MV_W-1:0] BK3_VOUT_BASE_MV = 12'h708;   // 1800 mV at code 0
  localparam logic [BK3_MV_W-1:0] BK3_VOUT_STEP_MV = 12'h064;   // 100 mV per code step
  localparam logic [BK3_MV_W-1:0] BK3_VOUT_MAX_MV = 12'hCE4;    // 3300 mV at code 15

  // ----------------------------------------------------------------
  // Synchronised pin positions
  // ----------------------------------------------------------------
  localparam int BK3_PIN_N = 4;
  localparam int BK3_PIN_HS = 0;               // High-side over-limit comparator
  localparam int BK3_PIN_LS = 1;               // Low-side over-limit comparator
  localparam int BK3_PIN_LIGHT = 2;            // Light-load detector
  localparam int BK3_PIN_CYC = 3;              // Switching cycle start

  // ----------------------------------------------------------------
  // Enumerations and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BK3_PS_REGS_OFF, BK3_PS_RUN, BK3_PS_STANDBY, BK3_PS_SLEEP} bk3_pstate_t;
  typedef enum logic [1:0] {BK3_MODE_OFF, BK3_MODE_ADAPTIVE, BK3_MODE_FPWM, BK3_MODE_LOW_BIAS} bk3_mode_t;

  typedef struct packed {
    bk3_mode_t mode;
    logic regulator_on;
    logic switching_on;
    logic discharge_on;
    logic pwm_forced;
    logic pulse_skip_on;
    logic low_bias_on;
    logic hs_block;
    logic ls_block;
    logic hs_sense;
    logic ls_sense;
    logic hs_status;
    logic ls_status;
    logic cyc_prev;
    logic [BK3_SP_W-1:0] run_sp;
    logic [BK3_SP_W-1:0] stby_sp;
    logic [BK3_SP_W-1:0] slp_sp;
    logic [BK3_SP_W-1:0] act_sp;
    logic [BK3_MV_W-1:0] target_mv;
    bk3_pstate_t prev_state;
  } bk3_state_t;

endpackage

//--- core/bk3_sync2.sv
/*
  Two-flop synchroniser for a vector of asynchronous pin levels.
  Assumes the pins are quasi-static levels; no grouping between bits is kept.
*/
`timescale 1ns/1ps
module bk3_sync2
  import bk3_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Pins in, synchronised levels out
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] s1;   // First stage, read only by the second
    logic [W-1:0] s2;   // Second stage, safe to use
  } bk3_sync_t;

  bk3_sync_t cur;
  bk3_sync_t next_cur;

  // Shift chain
  always_comb
  begin
    next_cur = cur;
    next_cur.s1 = pin_async;
    next_cur.s2 = cur.s1;
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
      cur <= '0;
    else if (ce)
      cur <= next_cur;
  end

  assign pin_sync = cur.s2;

endmodule

//--- core/bk3_debounce.sv
/*
  Fault persistence timer: pulses once when a fault level has held longer than a cycle count.
  Assumes the fault input is already synchronised to mclk.
*/
`timescale 1ns/1ps
module bk3_debounce
  import bk3_pkg::*;
(
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Debounce length in cycles
  input wire logic [BK3_DB_W-1:0] limit,
  // Fault level in, expiry pulse out
  input wire logic fault,
  output logic expired
);

  typedef struct packed {
    logic [BK3_DB_W:0] count;   // Cycles the fault has held
    logic expired;              // One-cycle expiry pulse
  } bk3_db_t;

  bk3_db_t cur;
  bk3_db_t next_cur;

  // Count while the fault holds, restart on any gap
  always_comb
  begin
    next_cur = cur;
    next_cur.expired = 1'b0;
    if (!fault)
      next_cur.count = '0;
    else if (cur.count <= {1'b0, limit})
    begin
      next_cur.count = cur.count + 1'b1;
      // Strictly longer than the limit
      next_cur.expired = (cur.count == {1'b0, limit});
    end
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
      cur <= '0;
    else if (ce)
      cur <= next_cur;
  end

  assign expired = cur.expired;

endmodule

//--- core/bk3_mode_ctrl.sv
/*
  Mode decode, current-limit handling and set-point loading for the third buck converter.
  Assumes control bits and power state come from same-clock register and state logic;
  comparator and cycle-start pins are asynchronous and are synchronised here.
*/
// Behaviour
// - DCM/CCM follows load; host or state forces
// - Off mode: no switching, discharge enabled
// - Adaptive is default; skips pulses at light load
// - Forced PWM never pulse skips
// - Low bias only in Standby/Sleep with bit
// - Enable and keep-on bits gate regulator per state
// - Forced-PWM bit overrides low-power bit
// - Both bits clear: adaptive with light-load DCM
// - Run with low-power bit stays adaptive
// - Standby with bits set runs low bias
// - Sleep with bits set runs low bias
// - Over-limit switch blocked for rest of cycle
// - Sense bits follow live limit condition
// - Status set after fault exceeds 8.0 ms
// - Fused code copied on disabled-to-Run entry
// - Set-point fields read-only, writes ignored
// - Code 0 is 1.80 V, 100 mV steps
`timescale 1ns/1ps
module bk3_mode_ctrl
  import bk3_pkg::*;
#(
  parameter logic [BK3_DB_W-1:0] DEBOUNCE_CYCLES = BK3_DEBOUNCE_CYCLES
)
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Chip power state
  input wire bk3_pstate_t power_state,
  // Control bits from the register file
  input wire logic buck_enable_bit,
  input wire logic standby_keep_on_bit,
  input wire logic sleep_keep_on_bit,
  input wire logic low_bias_select_bit,
  input wire logic forced_pwm_bit,
  input wire logic [BK3_SP_W-1:0] fused_setpoint_code,
  // Status clear strobes, write-one-to-clear
  input wire logic hs_status_clear,
  input wire logic ls_status_clear,
  // Asynchronous analog pins
  input wire logic hs_over_limit,
  input wire logic ls_over_limit,
  input wire logic light_load,
  input wire logic cycle_start,
  // Power stage controls
  output logic regulator_on,
  output logic switching_enable,
  output logic discharge_on,
  output logic pwm_forced,
  output logic pulse_skip_on,
  output logic low_bias_on,
  output logic hs_gate_block,
  output logic ls_gate_block,
  // Interrupt sense and status
  output logic hs_limit_sense,
  output logic ls_limit_sense,
  output logic hs_limit_status,
  output logic ls_limit_status,
  // Read-only set-point registers
  output logic [BK3_SP_W-1:0] buck3_run_setpoint,
  output logic [BK3_SP_W-1:0] buck3_standby_setpoint,
  output logic [BK3_SP_W-1:0] buck3_sleep_setpoint,
  // Active target voltage
  output logic [BK3_SP_W-1:0] active_setpoint,
  output logic [BK3_MV_W-1:0] active_target_mv
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bk3_state_t cur;                 // All registered state
  bk3_state_t next_cur;            // Next value of the state
  logic [BK3_PIN_N-1:0] pins_raw;  // Pins gathered for the synchroniser
  logic [BK3_PIN_N-1:0] pins_s;    // Synchronised pins
  logic hs_s;                      // Live high-side limit
  logic ls_s;                      // Live low-side limit
  logic light_s;                   // Light load seen
  logic cyc_s;                     // Cycle start level
  logic hs_expired;                // High-side fault held past debounce
  logic ls_expired;                // Low-side fault held past debounce
  logic en_state;                  // Regulator allowed in this power state
  logic lp_state;                  // Standby or Sleep
  logic cyc_new;                   // New switching cycle begins
  logic sp_load;                   // Start-up copy of the fused code
  bk3_mode_t sel_mode;             // Decoded operating mode

  // ----------------------------------------------------------------
  // Pin synchronisation and debounce timers
  // ----------------------------------------------------------------
  assign pins_raw = {cycle_start, light_load, ls_over_limit, hs_over_limit};

  bk3_sync2 #(.W(BK3_PIN_N)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .pin_async(pins_raw),
    .pin_sync(pins_s)
  );

  assign hs_s = pins_s[BK3_PIN_HS];
  assign ls_s = pins_s[BK3_PIN_LS];
  assign light_s = pins_s[BK3_PIN_LIGHT];
  assign cyc_s = pins_s[BK3_PIN_CYC];

  // High-side persistence
  bk3_debounce u_hs_db (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .limit(DEBOUNCE_CYCLES),
    .fault(hs_s),
    .expired(hs_expired)
  );

  // Low-side persistence
  bk3_debounce u_ls_db (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .limit(DEBOUNCE_CYCLES),
    .fault(ls_s),
    .expired(ls_expired)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Which power states allow the regulator
  always_comb
  begin
    lp_state = (power_state == BK3_PS_STANDBY) || (power_state == BK3_PS_SLEEP);
    en_state = 1'b0;
    if (!buck_enable_bit)
      en_state = 1'b0;
    else if (power_state == BK3_PS_RUN)
      en_state = 1'b1;
    else if (power_state == BK3_PS_STANDBY)
      en_state = standby_keep_on_bit;
    else if (power_state == BK3_PS_SLEEP)
      en_state = sleep_keep_on_bit;
  end

  // Mode selection; forced PWM wins over low bias
  always_comb
  begin
    if (!en_state)
      sel_mode = BK3_MODE_OFF;
    else if (forced_pwm_bit)
      sel_mode = BK3_MODE_FPWM;
    else if (low_bias_select_bit && lp_state)
      sel_mode = BK3_MODE_LOW_BIAS;
    else
      sel_mode = BK3_MODE_ADAPTIVE;
  end

  assign cyc_new = cyc_s && !cur.cyc_prev;
  assign sp_load = (cur.prev_state == BK3_PS_REGS_OFF) && (power_state == BK3_PS_RUN);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.mode = sel_mode;
    next_cur.prev_state = power_state;
    next_cur.cyc_prev = cyc_s;
    // Per-mode power stage controls
    case (sel_mode)
      BK3_MODE_OFF:
      begin
        next_cur.regulator_on = 1'b0;
        next_cur.switching_on = 1'b0;
        next_cur.discharge_on = 1'b1;
        next_cur.pwm_forced = 1'b0;
        next_cur.pulse_skip_on = 1'b0;
        next_cur.low_bias_on = 1'b0;
      end
      BK3_MODE_FPWM:
      begin
        next_cur.regulator_on = 1'b1;
        next_cur.switching_on = 1'b1;
        next_cur.discharge_on = 1'b0;
        next_cur.pwm_forced = 1'b1;
        next_cur.pulse_skip_on = 1'b0;
        next_cur.low_bias_on = 1'b0;
      end
      BK3_MODE_LOW_BIAS:
      begin
        next_cur.regulator_on = 1'b1;
        next_cur.switching_on = 1'b1;
        next_cur.discharge_on = 1'b0;
        next_cur.pwm_forced = 1'b0;
        next_cur.pulse_skip_on = light_s;
        next_cur.low_bias_on = 1'b1;
      end
      default:
      begin
        // Adaptive: quasi-fixed frequency, skipping at light load
        next_cur.regulator_on = 1'b1;
        next_cur.switching_on = 1'b1;
        next_cur.discharge_on = 1'b0;
        next_cur.pwm_forced = 1'b0;
        next_cur.pulse_skip_on = light_s;
        next_cur.low_bias_on = 1'b0;
      end
    endcase
    // Cycle-by-cycle switch blocking; a fault wins over the cycle restart
    if (hs_s)
      next_cur.hs_block = 1'b1;
    else if (cyc_new || !next_cur.switching_on)
      next_cur.hs_block = 1'b0;
    if (ls_s)
      next_cur.ls_block = 1'b1;
    else if (cyc_new || !next_cur.switching_on)
      next_cur.ls_block = 1'b0;
    // Live sense bits
    next_cur.hs_sense = hs_s;
    next_cur.ls_sense = ls_s;
    // Sticky status; a new expiry wins over the clear
    if (hs_expired)
      next_cur.hs_status = 1'b1;
    else if (hs_status_clear)
      next_cur.hs_status = 1'b0;
    if (ls_expired)
      next_cur.ls_status = 1'b1;
    else if (ls_status_clear)
      next_cur.ls_status = 1'b0;
    // Set-points change only through the start-up copy
    if (sp_load)
    begin
      next_cur.run_sp = fused_setpoint_code;
      next_cur.stby_sp = fused_setpoint_code;
      next_cur.slp_sp = fused_setpoint_code;
    end
    // Field used in the present state
    case (power_state)
      BK3_PS_STANDBY: next_cur.act_sp = next_cur.stby_sp;
      BK3_PS_SLEEP: next_cur.act_sp = next_cur.slp_sp;
      default: next_cur.act_sp = next_cur.run_sp;
    endcase
    // Linear decode of the low code bits
    next_cur.target_mv = BK3_MV_W'(BK3_VOUT_BASE_MV
      + BK3_MV_W'(next_cur.act_sp[BK3_CODE_W-1:0]) * BK3_VOUT_STEP_MV);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.mode <= BK3_MODE_OFF;
      cur.discharge_on <= 1'b1;
      cur.prev_state <= BK3_PS_REGS_OFF;
      cur.run_sp <= BK3_SP_RESET;
      cur.stby_sp <= BK3_SP_RESET;
      cur.slp_sp <= BK3_SP_RESET;
      cur.act_sp <= BK3_SP_RESET;
      cur.target_mv <= BK3_VOUT_BASE_MV;
    end
    else if (ce)
      cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regulator_on = cur.regulator_on;
  assign switching_enable = cur.switching_on;
  assign discharge_on = cur.discharge_on;
  assign pwm_forced = cur.pwm_forced;
  assign pulse_skip_on = cur.pulse_skip_on;
  assign low_bias_on = cur.low_bias_on;
  assign hs_gate_block = cur.hs_block;
  assign ls_gate_block = cur.ls_block;
  assign hs_limit_sense = cur.hs_sense;
  assign ls_limit_sense = cur.ls_sense;
  assign hs_limit_status = cur.hs_status;
  assign ls_limit_status = cur.ls_status;
  assign buck3_run_setpoint = cur.run_sp;
  assign buck3_standby_setpoint = cur.stby_sp;
  assign buck3_sleep_setpoint = cur.slp_sp;
  assign active_setpoint = cur.act_sp;
  assign active_target_mv = cur.target_mv;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking ck @(posedge mclk); endclocking
  default disable iff (rst);

  AST_OFF_DISCHARGE: assert property (ce && !buck_enable_bit |=> discharge_on && !switching_enable)
    else $error("Disabled regulator not discharged or still switching");
  AST_ADAPTIVE_SKIP: assert property (ce && en_state && !forced_pwm_bit && light_s |=> pulse_skip_on)
    else $error("Light load did not enable pulse skipping");
  AST_FPWM_NO_SKIP: assert property (ce && en_state && forced_pwm_bit |=> pwm_forced && !pulse_skip_on)
    else $error("Forced PWM not held");
  AST_FPWM_OVERRIDE: assert property (ce && en_state && forced_pwm_bit && low_bias_select_bit |=> !low_bias_on)
    else $error("Low bias applied despite forced PWM");
  AST_LOWBIAS_ONLY_LP: assert property (ce && power_state == BK3_PS_RUN |=> !low_bias_on)
    else $error("Low bias applied in Run");
  AST_RUN_ADAPTIVE: assert property (ce && buck_enable_bit && power_state == BK3_PS_RUN && !forced_pwm_bit
    |=> regulator_on && !pwm_forced && !low_bias_on)
    else $error("Run without forced PWM is not adaptive");
  AST_RUN_LP_BIT: assert property (ce && buck_enable_bit && power_state == BK3_PS_RUN && low_bias_select_bit
    && !forced_pwm_bit |=> regulator_on && !low_bias_on)
    else $error("Run with low-power bit left adaptive operation");
  AST_STBY_LOWBIAS: assert property (ce && buck_enable_bit && power_state == BK3_PS_STANDBY && standby_keep_on_bit
    && low_bias_select_bit && !forced_pwm_bit |=> low_bias_on && regulator_on)
    else $error("Standby low bias not entered");
  AST_SLP_LOWBIAS: assert property (ce && buck_enable_bit && power_state == BK3_PS_SLEEP && sleep_keep_on_bit
    && low_bias_select_bit && !forced_pwm_bit |=> low_bias_on && regulator_on)
    else $error("Sleep low bias not entered");
  AST_STBY_DISABLE: assert property (ce && power_state == BK3_PS_STANDBY && !standby_keep_on_bit
    |=> !regulator_on)
    else $error("Standby regulator on without keep-on bit");
  AST_HS_BLOCK: assert property (ce && hs_s |=> hs_gate_block)
    else $error("High-side switch not blocked over limit");
  AST_LS_SENSE: assert property (ce && ls_s |=> ls_limit_sense)
    else $error("Low-side sense does not follow the fault");
  AST_HS_STATUS_CAUSE: assert property ($rose(hs_limit_status) && $past(ce) && $past(ce, 2)
    |-> $past(hs_limit_sense))
    else $error("High-side status set without a held fault");
  AST_SP_COPY: assert property (ce && sp_load |=> buck3_sleep_setpoint == $past(fused_setpoint_code))
    else $error("Fused code not copied at start-up");
  AST_SP_READONLY: assert property (!sp_load |=> $stable(buck3_run_setpoint))
    else $error("Run set-point changed outside start-up copy");
  AST_MV_RANGE: assert property (active_target_mv >= BK3_VOUT_BASE_MV && active_target_mv <= BK3_VOUT_MAX_MV
    && active_target_mv == BK3_VOUT_BASE_MV + BK3_VOUT_STEP_MV * active_setpoint[BK3_CODE_W-1:0])
    else $error("Target voltage out of range");

  COV_FPWM: cover property (ce && $rose(pwm_forced));
  COV_LOWBIAS: cover property (ce && $rose(low_bias_on));
  COV_HS_STATUS: cover property ($rose(hs_limit_status));
  COV_SP_LOAD: cover property (ce && sp_load);

endmodule

//--- tb/bk3_stage_model.sv
/*
  Power stage stand-in: drives comparator, light-load and cycle-start pins.
  Assumes the bench requests fault and load levels; pins move off the clock edge.
*/
`timescale 1ns/1ps
module bk3_stage_model
#(
  parameter int CYC_PERIOD = 8
)
(
  // Clock
  input wire logic mclk,
  // Requested analog conditions
  input wire logic hs_req,
  input wire logic ls_req,
  input wire logic light_req,
  // Pins towards the block
  output logic hs_over_limit,
  output logic ls_over_limit,
  output logic light_load,
  output logic cycle_start
);
  int cyc_cnt; // Switching period counter

  // Quiet pins at time zero
  initial
  begin
    cyc_cnt = 0;
    {hs_over_limit, ls_over_limit, light_load, cycle_start} = 4'h0;
  end

  // Pins settle 3 ns after the edge, so they look asynchronous
  always @(posedge mclk)
  begin
    #3;
    hs_over_limit = hs_req;
    ls_over_limit = ls_req;
    light_load = light_req;
    cyc_cnt = (cyc_cnt + 1) % CYC_PERIOD;
    cycle_start = (cyc_cnt == 0);
  end
endmodule

//--- tb/test_buck3_mode_and_setpoint_control.sv
/*
  Self-checking bench for the buck mode and set-point control.
  Assumes bk3_pkg is compiled first; debounce is shortened to 20 cycles.
*/
`timescale 1ns/1ps
module test_buck3_mode_and_setpoint_control;
  import bk3_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [BK3_DB_W-1:0] DB = BK3_DB_W'(20); // Short debounce
  logic mclk, rst, ce, en, stby, slp, lp, fp, hs_clr, ls_clr;
  logic hs_req, ls_req, light_req, hs_pin, ls_pin, light_pin, cyc_pin;
  bk3_pstate_t ps; // Chip power state
  logic [5:0] fused, run_sp, stby_sp, slp_sp, act_sp;
  logic [11:0] mv;
  logic reg_on, sw_en, dis_on, pwm_f, skip_on, lb_on, hs_blk, ls_blk;
  logic hs_sen, ls_sen, hs_st, ls_st;
  logic [5:0] codes [4];
  logic [31:0] r;
  int errors, samples_checked, seed, k;

  bk3_mode_ctrl #(.DEBOUNCE_CYCLES(DB)) DUT (.mclk(mclk), .rst(rst), .ce(ce), .power_state(ps),
    .buck_enable_bit(en), .standby_keep_on_bit(stby), .sleep_keep_on_bit(slp),
    .low_bias_select_bit(lp), .forced_pwm_bit(fp), .fused_setpoint_code(fused),
    .hs_status_clear(hs_clr), .ls_status_clear(ls_clr), .hs_over_limit(hs_pin),
    .ls_over_limit(ls_pin), .light_load(light_pin), .cycle_start(cyc_pin),
    .regulator_on(reg_on), .switching_enable(sw_en), .discharge_on(dis_on), .pwm_forced(pwm_f),
    .pulse_skip_on(skip_on), .low_bias_on(lb_on), .hs_gate_block(hs_blk), .ls_gate_block(ls_blk),
    .hs_limit_sense(hs_sen), .ls_limit_sense(ls_sen), .hs_limit_status(hs_st),
    .ls_limit_status(ls_st), .buck3_run_setpoint(run_sp), .buck3_standby_setpoint(stby_sp),
    .buck3_sleep_setpoint(slp_sp), .active_setpoint(act_sp), .active_target_mv(mv));

  bk3_stage_model STAGE (.mclk(mclk), .hs_req(hs_req), .ls_req(ls_req), .light_req(light_req),
    .hs_over_limit(hs_pin), .ls_over_limit(ls_pin), .light_load(light_pin), .cycle_start(cyc_pin));

  // ------------------------------------------------------------
  // Clock, watchdog and helpers
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    test_done();
  end

  // Wait n edges, then past the edge updates
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Single-bit result
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Multi-bit result
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Reference decode of the mode table
  task automatic check_mode;
    logic on;
    on = en && (ps == BK3_PS_RUN || (ps == BK3_PS_STANDBY && stby) || (ps == BK3_PS_SLEEP && slp));
    chk_bit(reg_on, on);
    chk_bit(sw_en, on);
    chk_bit(dis_on, !on);
    chk_bit(pwm_f, on && fp);
    chk_bit(lb_on, on && !fp && lp && ps != BK3_PS_RUN);
    chk_bit(skip_on, on && !fp);
  endtask

  // Count summary and verdict
  task automatic test_done;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    errors = 0;
    samples_checked = 0;
    seed = 84396;
    {rst, ce} = 2'b11;
    ps = BK3_PS_REGS_OFF;
    {en, stby, slp, lp, fp, hs_clr, ls_clr, hs_req, ls_req} = 9'h000;
    light_req = 1'b1;
    fused = 6'h00;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    tick(0);
    chk_bit(dis_on, 1'b1);
    chk_val(mv, 12'h708);
    // Start-up copy of the fused code, boundary codes first
    codes = '{6'h00, 6'h0F, 6'h3F, 6'h00};
    codes[3] = 6'($random(seed));
    foreach (codes[i])
    begin
      @(posedge mclk);
      {ps, en, stby, fused} <= {BK3_PS_REGS_OFF, 2'b11, codes[i]};
      tick(2);
      @(posedge mclk);
      ps <= BK3_PS_RUN;
      tick(3);
      chk_val(12'(run_sp), 12'(codes[i]));
      chk_val(12'(stby_sp), 12'(codes[i]));
      chk_val(12'(slp_sp), 12'(codes[i]));
      chk_val(mv, 12'(1800 + 100 * codes[i][3:0]));
      // New fuse value and a Standby trip must not reload
      @(posedge mclk);
      {fused, ps} <= {~codes[i], BK3_PS_STANDBY};
      tick(3);
      chk_val(12'(act_sp), 12'(codes[i]));
      @(posedge mclk);
      ps <= BK3_PS_RUN;
      tick(3);
      chk_val(12'(run_sp), 12'(codes[i]));
    end
    // Random sweep through the mode table under light load
    repeat (120)
    begin
      r = $random(seed);
      @(posedge mclk);
      {ps, en, stby, slp, lp, fp} <= {bk3_pstate_t'(r[1:0]), r[6:2]};
      tick(2);
      check_mode();
    end
    // Heavy load in adaptive mode: no skipping
    @(posedge mclk);
    {ps, en, lp, fp, light_req} <= {BK3_PS_RUN, 4'hC};
    tick(5);
    chk_bit(skip_on, 1'b0);
    chk_bit(lb_on, 1'b0);
    chk_bit(reg_on, 1'b1);
    // Clock enable low freezes the decode; forced PWM shows once it returns
    @(posedge mclk);
    {ce, fp} <= 2'b01;
    tick(3);
    chk_bit(pwm_f, 1'b0);
    @(posedge mclk);
    ce <= 1'b1;
    tick(2);
    chk_bit(pwm_f, 1'b1);
    chk_bit(lb_on, 1'b0);
    // Current limits: short fault, then one past the debounce
    for (k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      {hs_req, ls_req} <= {k == 0, k == 1};
      tick(5);
      chk_bit(k ? ls_sen : hs_sen, 1'b1);
      chk_bit(k ? ls_blk : hs_blk, 1'b1);
      @(posedge mclk);
      {hs_req, ls_req} <= 2'b00;
      tick(20);
      chk_bit(k ? ls_sen : hs_sen, 1'b0);
      chk_bit(k ? ls_blk : hs_blk, 1'b0);
      chk_bit(k ? ls_st : hs_st, 1'b0);
      @(posedge mclk);
      {hs_req, ls_req} <= {k == 0, k == 1};
      tick(int'(DB));
      chk_bit(k ? ls_st : hs_st, 1'b0);
      tick(10);
      chk_bit(k ? ls_st : hs_st, 1'b1);
      @(posedge mclk);
      {hs_req, ls_req, hs_clr, ls_clr} <= {2'b00, k == 0, k == 1};
      @(posedge mclk);
      {hs_clr, ls_clr} <= 2'b00;
      tick(2);
      chk_bit(k ? ls_st : hs_st, 1'b0);
    end
    test_done();
  end
endmodule
